//--- hdl/sar_pkg.sv
// Purpose: shared constants and types of the sar conversion sequencer
// Assumes: 20 MHz system clock, 14-bit result, three conversion modes
// Notes: period and acquisition cycle counts below are derived from rates and the clock

package sar_pkg;

   // ========================================================
   // clock and resolution
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned RES_BITS = 14;
   localparam int unsigned CNT_W = 5;

   // ========================================================
   // throughput: least start-to-start spacing, rounded up
   localparam int unsigned RATE_FAST_SPS = 1_000_000;
   localparam int unsigned RATE_NORMAL_SPS = 800_000;
   localparam int unsigned RATE_SAVE_SPS = 670_000;
   localparam int unsigned PER_FAST_CYC =
      (CLK_HZ + RATE_FAST_SPS - 1) / RATE_FAST_SPS;
   localparam int unsigned PER_NORMAL_CYC =
      (CLK_HZ + RATE_NORMAL_SPS - 1) / RATE_NORMAL_SPS;
   localparam int unsigned PER_SAVE_CYC =
      (CLK_HZ + RATE_SAVE_SPS - 1) / RATE_SAVE_SPS;

   // conversion: two switch steps, one cycle per bit, one cycle to form code
   localparam int unsigned SWITCH_STEPS = 2;
   localparam int unsigned DONE_STEPS = 1;
   localparam int unsigned CONV_CYC = SWITCH_STEPS + RES_BITS + DONE_STEPS;

   // acquisition interval per mode, what is left of the period
   localparam logic [CNT_W-1:0] ACQ_FAST_CYC = CNT_W'(PER_FAST_CYC - CONV_CYC);
   localparam logic [CNT_W-1:0] ACQ_NORMAL_CYC =
      CNT_W'(PER_NORMAL_CYC - CONV_CYC);
   localparam logic [CNT_W-1:0] ACQ_SAVE_CYC = CNT_W'(PER_SAVE_CYC - CONV_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

   // ========================================================
   // code constants
   localparam logic [3:0] MSB_IDX = 4'(RES_BITS - 1);
   localparam logic [3:0] IDX_ZERO = 4'h0;
   localparam logic [RES_BITS-1:0] CODE_ZERO = 14'h0000;
   localparam logic [RES_BITS-1:0] MSB_MASK = 14'h2000;

   // ========================================================
   // types
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_FAST = 2'h1,
      MODE_SAVE = 2'h2
   } mode_t;

   typedef struct packed {
      logic fast;    // fast select
      logic psave;   // power-save select
      logic bipolar; // bipolar range
      logic ten;     // 10 V range
   } cfg_t;

   localparam cfg_t CFG_RESET = 4'h0;

   typedef struct packed {
      logic comp_gnd; // comparator-side terminals to analog ground
      logic arr_in;   // array switches to the analog inputs
   } switch_t;

   localparam switch_t SW_SAMPLE = 2'h3;
   localparam switch_t SW_OPEN = 2'h1;
   localparam switch_t SW_CONVERT = 2'h0;

   // gray codes along acquire, open, ground, bits, done
   typedef enum logic [2:0] {
      ST_ACQ = 3'h0,
      ST_OPEN = 3'h1,
      ST_TO_GND = 3'h3,
      ST_BITS = 3'h2,
      ST_DONE = 3'h6
   } state_t;

   // pin decode of the two mode selects
   function automatic mode_t mode_of(input cfg_t c);
      mode_t m;
      m = MODE_NORMAL;
      case ({c.fast, c.psave})
         2'b10: m = MODE_FAST;
         2'b01: m = MODE_SAVE;
         default: m = MODE_NORMAL;
      endcase
      return m;
   endfunction : mode_of

   function automatic logic [CNT_W-1:0] acq_cyc(input mode_t m);
      logic [CNT_W-1:0] n;
      n = ACQ_NORMAL_CYC;
      case (m)
         MODE_FAST: n = ACQ_FAST_CYC;
         MODE_SAVE: n = ACQ_SAVE_CYC;
         default: n = ACQ_NORMAL_CYC;
      endcase
      return n;
   endfunction : acq_cyc

endpackage : sar_pkg

//--- hdl/pin_sync.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to clk
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   // ========================================================
   // one pair of flops per bit
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               meta_q <= RST_VAL[i];
               sync_q <= RST_VAL[i];
            end else begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate

endmodule : pin_sync
`default_nettype wire

//--- hdl/sar_bit_engine.sv
// Purpose: successive approximation trial register
// Assumes: comp is a latched comparator sampled on clk
// Notes: trial_q drives the array switches, 1 = reference, 0 = ground
`timescale 1ns/1ps
`default_nettype none

module sar_bit_engine (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic load,
   input wire logic step,
   input wire logic comp,
   output logic [sar_pkg::RES_BITS-1:0] trial_q,
   output logic [3:0] idx_q
);

   // ========================================================
   // bit pointer walks from msb to lsb
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         idx_q <= sar_pkg::MSB_IDX;
      end else if (load) begin
         idx_q <= sar_pkg::MSB_IDX;
      end else if (step && idx_q != sar_pkg::IDX_ZERO) begin
         idx_q <= idx_q - 4'h1;
      end
   end

   // ========================================================
   // per bit: decide the bit under test, raise the next one
   genvar b;
   generate
      for (b = 0; b < sar_pkg::RES_BITS; b++) begin : g_trial
         always_ff @(posedge clk) begin
            if (!rst_n || clear) begin
               trial_q[b] <= 1'b0;
            end else if (load) begin
               trial_q[b] <= sar_pkg::MSB_MASK[b];
            end else if (step && idx_q == 4'(b)) begin
               trial_q[b] <= comp; // keep or release
            end else if (step && idx_q == 4'(b + 1)) begin
               trial_q[b] <= 1'b1; // next lower weight
            end
         end
      end
   endgenerate

endmodule : sar_bit_engine
`default_nettype wire

//--- hdl/sar_conversion_sequencer.sv
// Purpose: acquisition and conversion sequencing of a 14-bit sar converter
// Assumes: comp_above is the latched comparator, same clock domain
// Notes: pins are synchronised, so starts are seen two cycles late
`timescale 1ns/1ps
`default_nettype none

module sar_conversion_sequencer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic convert_start_n,
   input wire logic sw_config,
   input wire sar_pkg::cfg_t cfg_pins,
   input wire sar_pkg::cfg_t ser_cfg,
   input wire logic ser_cfg_valid,
   input wire logic comp_above,
   output logic busy_q,
   output logic [sar_pkg::RES_BITS-1:0] code_q,
   output sar_pkg::switch_t sw_q,
   output logic [sar_pkg::RES_BITS-1:0] dac_q,
   output sar_pkg::cfg_t active_cfg_q,
   output sar_pkg::mode_t mode_q,
   output logic pwr_save_q
);

   // ========================================================
   // pin synchronisation
   localparam int PIN_W = 6;
   localparam logic [PIN_W-1:0] PIN_RST = 6'h20; // start pin idles high

   logic [PIN_W-1:0] pins_s;
   logic cnv_s;
   logic sw_s;
   sar_pkg::cfg_t pin_cfg_s;

   pin_sync #(
      .W(PIN_W),
      .RST_VAL(PIN_RST)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({convert_start_n, sw_config, cfg_pins}),
      .q(pins_s)
   );

   assign cnv_s = pins_s[5];
   assign sw_s = pins_s[4];
   assign pin_cfg_s = sar_pkg::cfg_t'(pins_s[3:0]);

   // ========================================================
   // state
   sar_pkg::state_t state_q;
   sar_pkg::state_t state_d;
   logic cnv_prev_q;
   logic cnv_fall;
   logic start_acc;
   logic bits_last;
   logic [sar_pkg::CNT_W-1:0] acq_cnt_q;
   logic acq_done;
   logic [3:0] idx_q;
   logic [sar_pkg::RES_BITS-1:0] trial_q;

   // ========================================================
   // configuration: serial word store, pending and active settings
   sar_pkg::cfg_t ser_q;
   sar_pkg::cfg_t sel_cfg;
   sar_pkg::cfg_t pend_q;
   logic [sar_pkg::CNT_W-1:0] cfg_cnt_q;

   // serial word is written by logic on clk, so no synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ser_q <= sar_pkg::CFG_RESET;
      end else if (ser_cfg_valid) begin
         ser_q <= ser_cfg;
      end
   end

   // source follows the software mode pin
   assign sel_cfg = sw_s ? ser_q : pin_cfg_s;

   // a change restarts the interval; only the last change is applied
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_q <= sar_pkg::CFG_RESET;
         cfg_cnt_q <= sar_pkg::CNT_ZERO;
      end else if (sel_cfg != pend_q) begin
         pend_q <= sel_cfg;
         cfg_cnt_q <= sar_pkg::acq_cyc(mode_q);
      end else if (cfg_cnt_q != sar_pkg::CNT_ZERO) begin
         cfg_cnt_q <= cfg_cnt_q - sar_pkg::CNT_ONE;
      end
   end

   // applied live, no reset of the sequencer needed
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         active_cfg_q <= sar_pkg::CFG_RESET;
         mode_q <= sar_pkg::MODE_NORMAL;
      end else if (cfg_cnt_q == sar_pkg::CNT_ONE) begin
         active_cfg_q <= pend_q;
         mode_q <= sar_pkg::mode_of(pend_q);
      end
   end

   // ========================================================
   // start detection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnv_prev_q <= 1'b1;
      end else begin
         cnv_prev_q <= cnv_s;
      end
   end

   assign cnv_fall = cnv_prev_q && !cnv_s;
   assign acq_done = (acq_cnt_q == sar_pkg::CNT_ZERO);
   // a fall during acquisition is dropped, the host must wait
   assign start_acc = cnv_fall && acq_done
      && (state_q == sar_pkg::ST_ACQ);
   assign bits_last = (state_q == sar_pkg::ST_BITS)
      && (idx_q == sar_pkg::IDX_ZERO);

   // ========================================================
   // sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         sar_pkg::ST_ACQ: begin
            if (start_acc) begin
               state_d = sar_pkg::ST_OPEN;
            end
         end
         sar_pkg::ST_OPEN: state_d = sar_pkg::ST_TO_GND;
         sar_pkg::ST_TO_GND: state_d = sar_pkg::ST_BITS;
         sar_pkg::ST_BITS: begin
            if (bits_last) begin
               state_d = sar_pkg::ST_DONE;
            end
         end
         sar_pkg::ST_DONE: state_d = sar_pkg::ST_ACQ;
         default: state_d = sar_pkg::ST_ACQ;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= sar_pkg::ST_ACQ;
      end else begin
         state_q <= state_d;
      end
   end

   // ========================================================
   // acquisition timer, sets the least start-to-start spacing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acq_cnt_q <= sar_pkg::ACQ_NORMAL_CYC;
      end else if (bits_last) begin
         acq_cnt_q <= sar_pkg::acq_cyc(mode_q);
      end else if (!acq_done) begin
         acq_cnt_q <= acq_cnt_q - sar_pkg::CNT_ONE;
      end
   end

   // ========================================================
   // switch control
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sw_q <= sar_pkg::SW_SAMPLE;
      end else begin
         case (state_d)
            sar_pkg::ST_OPEN: sw_q <= sar_pkg::SW_OPEN;
            sar_pkg::ST_TO_GND: sw_q <= sar_pkg::SW_CONVERT;
            sar_pkg::ST_BITS: sw_q <= sar_pkg::SW_CONVERT;
            default: sw_q <= sar_pkg::SW_SAMPLE;
         endcase
      end
   end

   // ========================================================
   // bit engine: cleared to ground on hold, msb trial on entering bits
   sar_bit_engine u_engine (
      .clk(clk),
      .rst_n(rst_n),
      .clear(state_d == sar_pkg::ST_OPEN),
      .load(state_d == sar_pkg::ST_BITS && state_q == sar_pkg::ST_TO_GND),
      .step(state_q == sar_pkg::ST_BITS),
      .comp(comp_above),
      .trial_q(trial_q),
      .idx_q(idx_q)
   );

   assign dac_q = trial_q;

   // ========================================================
   // result and busy; code is the sample just converted
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         code_q <= sar_pkg::CODE_ZERO;
      end else if (state_q == sar_pkg::ST_DONE) begin
         code_q <= trial_q;
      end
   end

   // drops together with the code update
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
      end else if (start_acc) begin
         busy_q <= 1'b1;
      end else if (state_q == sar_pkg::ST_DONE) begin
         busy_q <= 1'b0;
      end
   end

   // saving mode powers down between conversions
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwr_save_q <= 1'b0;
      end else begin
         pwr_save_q <= (mode_q == sar_pkg::MODE_SAVE)
            && (state_d == sar_pkg::ST_ACQ);
      end
   end

   // ========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // busy rises on the take edge and falls on the done edge
   localparam int CONV_TO_IDLE = sar_pkg::CONV_CYC;
   localparam int PER_FAST = sar_pkg::PER_FAST_CYC;

   logic [sar_pkg::CNT_W-1:0] since_q;
   logic seen_q;

   // helper: cycles since the last accepted start, saturating
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         since_q <= sar_pkg::CNT_ZERO;
         seen_q <= 1'b0;
      end else if (start_acc) begin
         since_q <= sar_pkg::CNT_ONE;
         seen_q <= 1'b1;
      end else if (since_q != sar_pkg::CNT_MAX) begin
         since_q <= since_q + sar_pkg::CNT_ONE;
      end
   end

   sequence s_open_then_ground;
      sw_q == sar_pkg::SW_OPEN ##1
      (sw_q == sar_pkg::SW_CONVERT && dac_q == sar_pkg::CODE_ZERO);
   endsequence

   sequence s_msb_trial;
      dac_q == sar_pkg::MSB_MASK;
   endsequence

   a_start_gate: assert property (
      start_acc |-> acq_done && $past(cnv_s) && !cnv_s)
      else $error("start taken before acquisition ended");
   a_switch_order: assert property (
      start_acc |=> s_open_then_ground ##1 s_msb_trial)
      else $error("switch order at conversion start wrong");
   a_acq_switches: assert property (
      state_q == sar_pkg::ST_ACQ |-> sw_q == sar_pkg::SW_SAMPLE && !busy_q)
      else $error("arrays not tracking during acquisition");
   a_busy_span: assert property (
      start_acc |=> busy_q ##CONV_TO_IDLE !busy_q)
      else $error("busy span differs from conversion length");
   a_code_fresh: assert property (
      state_q == sar_pkg::ST_DONE |=> code_q == $past(dac_q) && !busy_q)
      else $error("code not from current conversion");
   a_rate_limit: assert property (
      start_acc && seen_q |-> since_q >= sar_pkg::CNT_W'(PER_FAST))
      else $error("starts closer than fastest period");
   a_cfg_latch: assert property (
      cfg_cnt_q == sar_pkg::CNT_ONE && sel_cfg == pend_q
      |=> active_cfg_q == $past(pend_q))
      else $error("pending setting not applied");
   a_cfg_hold: assert property (
      cfg_cnt_q > sar_pkg::CNT_ONE |=> $stable(active_cfg_q))
      else $error("setting applied before interval elapsed");
   a_bit_walk: assert property (
      state_q == sar_pkg::ST_BITS && idx_q != sar_pkg::IDX_ZERO
      |=> idx_q == $past(idx_q) - 4'h1 && dac_q[idx_q])
      else $error("bit pointer did not step msb first");

endmodule : sar_conversion_sequencer
`default_nettype wire

//--- testbench/sar_host_model.sv
// Purpose: host and analog front end beside the sar sequencer
// Assumes: ideal comparator, input held still while a conversion runs
// Notes: the start line is driven 2 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none

module sar_host_model (
   input wire logic clk,
   input wire logic [sar_pkg::RES_BITS-1:0] dac_q,
   output logic convert_start_n,
   output logic comp_above
);
   // ======================================================
   // analog side
   logic [sar_pkg::RES_BITS-1:0] vin;

   // input at or above the trial level keeps the bit
   assign comp_above = (vin >= dac_q);

   // idle start line is high, input starts at zero scale
   initial begin
      vin = 14'h0000;
      convert_start_n = 1'b1;
   end

   // ======================================================
   // start pulses
   // two low, two high; falls landing in busy or acquisition are
   // lost, so the take rate is the device's own limit
   task automatic hammer(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         #2;
         convert_start_n = i[1];
      end
      @(posedge clk);
      #2;
      convert_start_n = 1'b1;
   endtask : hammer
   // fast mode gaps stay far below 1 ms, so no result is dropped
endmodule : sar_host_model
`default_nettype wire

//--- testbench/tb.sv
// Purpose: self-checking bench of the sar conversion sequencer
// Assumes: 20 MHz clock, host model drives starts and comparator
// Notes: expected codes, rates and config delays come from a bench model
`timescale 1ns/1ps
`default_nettype none

module tb;
   // ======================================================
   // clock, stimulus and design
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sw_config = 1'b0;
   logic ser_cfg_valid = 1'b0;
   sar_pkg::cfg_t cfg_pins = sar_pkg::CFG_RESET;
   sar_pkg::cfg_t ser_cfg = sar_pkg::CFG_RESET;
   logic convert_start_n, comp_above, busy_q, pwr_save_q, busy_seen;
   logic [13:0] code_q, dac_q;
   sar_pkg::switch_t sw_q;
   sar_pkg::cfg_t active_cfg_q, new_cfg;
   sar_pkg::mode_t mode_q, cur_mode;
   int n_mismatch = 0;
   int total_checks = 0;
   int seed = 32'hE0A4;
   int cyc = 0, t_rise = 0, last_rise = -1, min_per, max_per, nconv = 0;
   int lat, per, n_acq, w;
   int exp_q[$];
   logic [1:0] sel[5] = '{2'b10, 2'b01, 2'b11, 2'b00, 2'b01};

   always #25 clk = ~clk;

   sar_conversion_sequencer i_dut (.clk(clk), .rst_n(rst_n),
      .convert_start_n(convert_start_n), .sw_config(sw_config),
      .cfg_pins(cfg_pins), .ser_cfg(ser_cfg),
      .ser_cfg_valid(ser_cfg_valid), .comp_above(comp_above),
      .busy_q(busy_q), .code_q(code_q), .sw_q(sw_q), .dac_q(dac_q),
      .active_cfg_q(active_cfg_q), .mode_q(mode_q),
      .pwr_save_q(pwr_save_q));

   sar_host_model i_host (.clk(clk), .dac_q(dac_q),
      .convert_start_n(convert_start_n), .comp_above(comp_above));

   // ======================================================
   // shared tasks and bench model
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // pin pair {fast, save} to mode, both equal means normal
   function automatic sar_pkg::mode_t exp_mode(input logic [1:0] s);
      case (s)
         2'b10: return sar_pkg::MODE_FAST;
         2'b01: return sar_pkg::MODE_SAVE;
         default: return sar_pkg::MODE_NORMAL;
      endcase
   endfunction : exp_mode

   // least start spacing in cycles, rate rounded up to whole cycles
   function automatic int per_of(input sar_pkg::mode_t m);
      int r;
      r = (m == sar_pkg::MODE_FAST) ? 1_000_000 :
         (m == sar_pkg::MODE_SAVE) ? 670_000 : 800_000;
      return (20_000_000 + r - 1) / r;
   endfunction : per_of

   // count edges until the new setting shows, bounded
   task automatic wait_cfg(input sar_pkg::cfg_t c, output int n);
      n = 0;
      while (active_cfg_q !== c && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 60) begin
         n_mismatch++;
         end_of_test();
      end
   endtask : wait_cfg

   // ======================================================
   // monitor: sequence of one conversion, checked at every result
   always @(posedge clk) begin
      cyc++;
      if (rst_n && busy_q && !busy_seen) begin
         check("switches at start", sw_q, sar_pkg::SW_OPEN);
         if (last_rise >= 0) begin
            min_per = (cyc - last_rise < min_per) ? cyc - last_rise : min_per;
            max_per = (cyc - last_rise > max_per) ? cyc - last_rise : max_per;
         end
         exp_q.push_back(int'(i_host.vin));
         last_rise = cyc;
         t_rise = cyc;
      end
      if (busy_q && cyc - t_rise == 1) begin
         check("switches convert", sw_q, sar_pkg::SW_CONVERT);
      end
      if (busy_q && cyc - t_rise == 2) begin
         check("first trial", dac_q, sar_pkg::MSB_MASK);
      end
      if (rst_n && !busy_q && busy_seen) begin
         check("busy length", cyc - t_rise, sar_pkg::CONV_CYC);
         check("code", code_q, exp_q.pop_front());
         // boundary codes first, then random levels
         i_host.vin <= (nconv == 0) ? 14'h3FFF : (nconv == 1) ? 14'h2000 :
            (nconv == 2) ? 14'h1FFF : 14'($random(seed));
         nconv++;
      end
      if (rst_n && !busy_q) begin
         check("switches sample", sw_q, sar_pkg::SW_SAMPLE);
      end
      busy_seen = busy_q;
   end

   // ======================================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      #2;
      rst_n = 1'b1;
      @(posedge clk);
      #2;
      check("busy after reset", busy_q, 1'b0);
      check("code after reset", code_q, 14'h0000);
      check("switches after reset", sw_q, sar_pkg::SW_SAMPLE);
      check("mode after reset", mode_q, sar_pkg::MODE_NORMAL);
      cur_mode = sar_pkg::MODE_NORMAL;
      // each step: change setting, time its delay, then run at full rate
      for (int k = 0; k < 5; k++) begin
         new_cfg = {sel[k], 2'($random(seed))};
         n_acq = per_of(cur_mode) - 17;
         if (k == 4) begin
            // serial word takes over, pins are moved to be ignored
            ser_cfg = new_cfg;
            ser_cfg_valid = 1'b1;
            @(posedge clk);
            #2;
            ser_cfg_valid = 1'b0;
            sw_config = 1'b1;
            cfg_pins = ~new_cfg;
         end else begin
            cfg_pins = new_cfg;
         end
         wait_cfg(new_cfg, lat);
         check("config delay floor", lat >= n_acq + 1, 1'b1);
         check("config delay ceiling", lat <= n_acq + 6, 1'b1);
         cur_mode = exp_mode(sel[k]);
         check("mode", mode_q, cur_mode);
         per = per_of(cur_mode);
         min_per = 1000;
         max_per = 0;
         last_rise = -1;
         i_host.hammer(4 * per + 12);
         w = 0;
         while (busy_q !== 1'b0 && w < 40) begin
            @(posedge clk);
            #2;
            w++;
         end
         check("conversion idle", busy_q, 1'b0);
         check("power save", pwr_save_q, cur_mode == sar_pkg::MODE_SAVE);
         check("rate floor", min_per >= per, 1'b1);
         check("rate ceiling", max_per <= per + 4, 1'b1);
      end
      check("results seen", nconv >= 15, 1'b1);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
